// File: inc/tsima_pkg.sv
/*
  Constants shared by the memory addressing block of the time slot switch:
  control register fields, memory select codes, field layouts of the
  connection memories, sizes and access timing counts.
  Assumes a 20 MHz system clock.
*/
`default_nettype none
package tsima_pkg;
  // -------------------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------------------
  localparam int unsigned STREAMS    = 8;
  localparam int unsigned CHANNELS   = 32;
  localparam int unsigned MEM_DEPTH  = STREAMS * CHANNELS;
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned BYTE_W     = 8;

  // -------------------------------------------------------------------------
  // host address lines and control register layout
  // -------------------------------------------------------------------------
  localparam int unsigned PAGE_SELECT_LINE = 5;
  localparam int unsigned CR_SPLIT_BIT     = 7;
  localparam int unsigned CR_PE_BIT        = 6;
  localparam int unsigned CR_SEL_MSB       = 4;
  localparam int unsigned CR_SEL_LSB       = 3;
  localparam int unsigned CR_STREAM_MSB    = 2;
  localparam logic [7:0]  CR_RESET         = 8'h00;

  // memory select codes carried in the control bits above the stream page bits
  localparam logic [1:0] MSEL_NONE = 2'h0;
  localparam logic [1:0] MSEL_CMH  = 2'h1;
  localparam logic [1:0] MSEL_CML  = 2'h2;
  localparam logic [1:0] MSEL_DM   = 2'h3;

  // -------------------------------------------------------------------------
  // connection memory fields
  // -------------------------------------------------------------------------
  localparam int unsigned SRC_STREAM_MSB = 7;
  localparam int unsigned SRC_STREAM_LSB = 5;
  localparam int unsigned SRC_CHAN_MSB   = 4;
  localparam int unsigned CMH_PROC_BIT   = 2;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned CM_ACK_MAX_NS   = 800;
  localparam int unsigned CM_ACK_MAX_CYC  = CM_ACK_MAX_NS / CLK_PERIOD_NS;

  // host access states
  typedef enum logic [1:0] {
    TSIMA_IDLE,
    TSIMA_WAIT,
    TSIMA_ACK
  } tsima_state_t;

  // stream and channel to memory index
  function automatic logic [IDX_W-1:0] tsima_index(input logic [2:0] stream,
                                                   input logic [4:0] chan);
    tsima_index = {stream, chan};
  endfunction : tsima_index
endpackage : tsima_pkg
`default_nettype wire

// File: inc/tsima_mem_if.sv
/*
  Interface between the addressing logic and one 256-byte memory:
  one write port and two registered read ports.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface tsima_mem_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr_a;
  logic [7:0] rdata_a;
  logic [7:0] raddr_b;
  logic [7:0] rdata_b;

  modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface : tsima_mem_if
`default_nettype wire

// File: design/tsima_mem.sv
/*
  Small 256 x 8 memory with one write port and two read ports whose data
  come out of registers one clock after the address.
  Assumes a single clock; contents are undefined after power up.
*/
`timescale 1ns/1ns
`default_nettype none
module tsima_mem
  import tsima_pkg::*;
(
  input  wire logic   clk_i,
  tsima_mem_if.mem    port
);
  logic [BYTE_W-1:0] store_q [MEM_DEPTH];

  // write port; no reset, like the real array
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      store_q[port.waddr] <= port.wdata;
    end
  end

  // registered reads, old data on a same-address write
  always_ff @(posedge clk_i) begin
    port.rdata_a <= store_q[port.raddr_a];
    port.rdata_b <= store_q[port.raddr_b];
  end
endmodule : tsima_mem
`default_nettype wire

// File: design/tsima_top.sv
/*
  Address decode and memory field logic behind the parallel host port of a
  256-channel time slot switch: control register, paged window onto the
  source-select, output-control and data memories, and the per-slot lookup
  that tells the serial side what to transmit.
  Assumes host pins are asynchronous to clk_i; slot and receive ports are
  driven by logic on clk_i.
*/
// Functional notes
// [RULE_01] control register only when page line low
// [RULE_02] page line low ignores all other addresses
// [RULE_03] page line high opens 32-byte page
// [RULE_04] low address lines give channel number
// [RULE_05] source byte bits 7-5 name stream
// [RULE_06] source byte bits 4-0 name channel
// [RULE_07] processor bit or enable sends byte itself
// [RULE_08] otherwise byte addresses input channel data
// [RULE_09] split mode reads data, writes source-select
// [RULE_10] data memory is read only from host
// [RULE_11] memory select routes paged accesses
// [RULE_12] one source byte per output channel
`timescale 1ns/1ns
`default_nettype none
module tsima_top
  import tsima_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       cs_n_i,
  input  wire logic       ds_i,
  input  wire logic       rw_i,
  input  wire logic [5:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  output logic            transfer_ack_n_o,
  output logic            transfer_ack_oe_o,
  input  wire logic       slot_req_i,
  input  wire logic [2:0] slot_stream_i,
  input  wire logic [4:0] slot_chan_i,
  input  wire logic       rx_wr_i,
  input  wire logic [2:0] rx_stream_i,
  input  wire logic [4:0] rx_chan_i,
  input  wire logic [7:0] rx_data_i,
  output logic            slot_valid_o,
  output logic            slot_direct_o,
  output logic      [2:0] slot_src_stream_o,
  output logic      [4:0] slot_src_chan_o,
  output logic      [7:0] slot_data_o,
  output logic            processor_output_mode_o
);
  // -------------------------------------------------------------------------
  // host pin synchronisers
  // -------------------------------------------------------------------------
  logic [16:0]  pins_m_q;
  logic [16:0]  pins_s_q;
  logic         cs_s;
  logic         ds_s;
  logic         rd_s;
  logic [5:0]   addr_s;
  logic [7:0]   wdat_s;

  // two stages before any logic looks at a pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pins_m_q <= 17'h00001;
      pins_s_q <= 17'h00001;
    end else begin
      pins_m_q <= {data_i, addr_i, rw_i, ds_i, cs_n_i};
      pins_s_q <= pins_m_q;
    end
  end
  assign cs_s   = ~pins_s_q[0];
  assign ds_s   = pins_s_q[1];
  assign rd_s   = pins_s_q[2];
  assign addr_s = pins_s_q[8:3];
  assign wdat_s = pins_s_q[16:9];

  // -------------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------------
  logic [7:0]   ctrl_q;
  logic [1:0]   msel;
  logic         split;
  logic         sel_ctrl;
  logic [7:0]   host_idx;
  tsima_state_t state_q;
  logic         start;

  assign msel     = ctrl_q[CR_SEL_MSB:CR_SEL_LSB];          // [RULE_11]
  assign split    = ctrl_q[CR_SPLIT_BIT];
  assign sel_ctrl = ~addr_s[PAGE_SELECT_LINE];              // [RULE_01] [RULE_02]
  // the page bits pick the stream, the low lines pick the channel
  assign host_idx = tsima_index(ctrl_q[CR_STREAM_MSB:0], addr_s[4:0]); // [RULE_03] [RULE_04]
  assign start    = (state_q == TSIMA_IDLE) && cs_s && ds_s;
  assign processor_output_mode_o = ctrl_q[CR_PE_BIT];

  // -------------------------------------------------------------------------
  // memories
  // -------------------------------------------------------------------------
  tsima_mem_if cml_if ();
  tsima_mem_if cmh_if ();
  tsima_mem_if dm_if ();

  tsima_mem u_cml (.clk_i(clk_i), .port(cml_if.mem));      // [RULE_12]
  tsima_mem u_cmh (.clk_i(clk_i), .port(cmh_if.mem));
  tsima_mem u_dm  (.clk_i(clk_i), .port(dm_if.mem));

  logic host_wr;
  logic wr_cml;
  logic wr_cmh;

  assign host_wr = start && !rd_s && !sel_ctrl;
  // split mode forces writes into the source-select memory
  assign wr_cml  = host_wr && (split || msel == MSEL_CML);  // [RULE_09] [RULE_11]
  assign wr_cmh  = host_wr && !split && msel == MSEL_CMH;   // [RULE_11]

  assign cml_if.we      = wr_cml;
  assign cml_if.waddr   = host_idx;
  assign cml_if.wdata   = wdat_s;
  assign cml_if.raddr_a = host_idx;
  assign cmh_if.we      = wr_cmh;
  assign cmh_if.waddr   = host_idx;
  assign cmh_if.wdata   = wdat_s;
  assign cmh_if.raddr_a = host_idx;
  // only the receive side fills the data memory
  assign dm_if.we       = rx_wr_i;                          // [RULE_10]
  assign dm_if.waddr    = tsima_index(rx_stream_i, rx_chan_i);
  assign dm_if.wdata    = rx_data_i;
  assign dm_if.raddr_a  = host_idx;

  // -------------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q <= CR_RESET;
    end else if (start && !rd_s && sel_ctrl) begin
      ctrl_q <= wdat_s;                                     // [RULE_01] [RULE_02]
    end
  end

  // -------------------------------------------------------------------------
  // host access sequencer
  // -------------------------------------------------------------------------
  logic [7:0] rsel;

  // read source: memory reads come out one clock after the address
  always_comb begin
    rsel = 8'h00;
    if (split) begin
      rsel = dm_if.rdata_a;                                 // [RULE_09]
    end else begin
      unique case (msel)
        MSEL_CMH:  rsel = cmh_if.rdata_a;                   // [RULE_11]
        MSEL_CML:  rsel = cml_if.rdata_a;
        MSEL_DM:   rsel = dm_if.rdata_a;
        MSEL_NONE: rsel = 8'h00;
      endcase
    end
  end

  // ack stays asserted until the host drops its strobe or its chip select
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= TSIMA_IDLE;
      data_o  <= 8'h00;
    end else begin
      unique case (state_q)
        TSIMA_IDLE: begin
          if (start && sel_ctrl) begin
            data_o  <= ctrl_q;
            state_q <= TSIMA_ACK;
          end else if (start) begin
            state_q <= TSIMA_WAIT;
          end
        end
        TSIMA_WAIT: begin
          data_o  <= rsel;
          state_q <= TSIMA_ACK;
        end
        TSIMA_ACK: begin
          if (!ds_s || !cs_s) begin
            state_q <= TSIMA_IDLE;
          end
        end
      endcase
    end
  end

  // open-drain acknowledge: pin pulled low only while enabled
  assign transfer_ack_n_o  = 1'b0;
  assign transfer_ack_oe_o = (state_q == TSIMA_ACK);
  assign data_oe_o         = (state_q == TSIMA_ACK) && rd_s;

  // -------------------------------------------------------------------------
  // per-slot lookup for the serial side
  // -------------------------------------------------------------------------
  logic       look1_q;
  logic       look2_q;
  logic       direct_q;
  logic [7:0] byte_q;

  assign cml_if.raddr_b = tsima_index(slot_stream_i, slot_chan_i);
  assign cmh_if.raddr_b = tsima_index(slot_stream_i, slot_chan_i);
  // the source byte itself is the data memory address
  assign dm_if.raddr_b  = cml_if.rdata_b;                   // [RULE_08]

  // three-step pipe: connection memories, data memory, output
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      look1_q  <= 1'b0;
      look2_q  <= 1'b0;
      direct_q <= 1'b0;
      byte_q   <= 8'h00;
    end else begin
      look1_q  <= slot_req_i;
      look2_q  <= look1_q;
      direct_q <= cmh_if.rdata_b[CMH_PROC_BIT] | ctrl_q[CR_PE_BIT]; // [RULE_07]
      byte_q   <= cml_if.rdata_b;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slot_valid_o      <= 1'b0;
      slot_direct_o     <= 1'b0;
      slot_src_stream_o <= 3'h0;
      slot_src_chan_o   <= 5'h00;
      slot_data_o       <= 8'h00;
    end else begin
      slot_valid_o      <= look2_q;
      slot_direct_o     <= direct_q;
      slot_src_stream_o <= byte_q[SRC_STREAM_MSB:SRC_STREAM_LSB]; // [RULE_05]
      slot_src_chan_o   <= byte_q[SRC_CHAN_MSB:0];                // [RULE_06]
      slot_data_o       <= direct_q ? byte_q : dm_if.rdata_b;     // [RULE_07] [RULE_08]
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_ctrl_write;
    start && !rd_s && sel_ctrl;
  endsequence
  sequence s_ack_seen;
    ##[1:2] transfer_ack_oe_o;
  endsequence

  chk_ctrl_write_any: assert property (s_ctrl_write |=> ctrl_q == $past(wdat_s)) // [RULE_01]
    else $error("control write at low page line lost");
  chk_ctrl_alias_ack: assert property (s_ctrl_write |-> s_ack_seen) // [RULE_02]
    else $error("control access not acknowledged");
  chk_page_read: assert property (start && !sel_ctrl |-> ##2 transfer_ack_oe_o // [RULE_03]
                                  && data_o == $past(rsel))
    else $error("paged access data or acknowledge late");
  chk_page_no_ctrl: assert property (start && addr_s[5] |=> $stable(ctrl_q)) // [RULE_01]
    else $error("paged access touched control register");
  chk_src_fields: assert property (look2_q |=> slot_src_stream_o == $past(byte_q[7:5])
                                   && slot_src_chan_o == $past(byte_q[4:0])) // [RULE_05]
    else $error("source fields wrong");
  chk_direct_data: assert property (look2_q && direct_q |=> slot_data_o == $past(byte_q)) // [RULE_07]
    else $error("direct byte not sent");
  chk_switch_data: assert property (look1_q ##1 !direct_q |=> slot_data_o == $past(dm_if.rdata_b)) // [RULE_08]
    else $error("switched data wrong");
  chk_split_write: assert property (host_wr && split |-> wr_cml && !wr_cmh) // [RULE_09]
    else $error("split write misrouted");
  chk_dm_readonly: assert property (host_wr && !split && msel == MSEL_DM |-> !wr_cml && !wr_cmh // [RULE_10]
                                    && dm_if.we == rx_wr_i)
    else $error("host wrote data memory");
  chk_cmh_route: assert property (wr_cmh |-> msel == MSEL_CMH && !split) // [RULE_11]
    else $error("output-control write misrouted");
endmodule : tsima_top
`default_nettype wire

// File: tb/tsima_host_model.sv
/*
  Host processor model for the parallel port: one strobed byte transfer
  per call, held until the acknowledge is sampled high.
  Assumes the device shares the bench clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tsima_host_model (
  input  wire logic       clk_i,
  input  wire logic       ack_oe_i,
  input  wire logic [7:0] rdata_i,
  output logic            cs_n_o,
  output logic            ds_o,
  output logic            rw_o,
  output logic      [5:0] addr_o,
  output logic      [7:0] data_o
);
  // idle bus: deselected, strobe low
  initial begin
    cs_n_o = 1'b1;
    ds_o   = 1'b0;
    rw_o   = 1'b1;
    addr_o = 6'h00;
    data_o = 8'h00;
  end

  // hold > 0 plays a slow host that keeps the strobe up after acknowledge
  task automatic access(input logic rw, input logic [5:0] a, input logic [7:0] wd,
                        input int hold, output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    ds_o   = 1'b1;
    rw_o   = rw;
    addr_o = a;
    data_o = wd;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk_i);
      if (ack_oe_i === 1'b1) begin
        ok = 1'b1;
        rd = rdata_i;
      end
    end
    repeat (hold) @(posedge clk_i);
    @(negedge clk_i);
    ds_o   = 1'b0;
    cs_n_o = 1'b1;
    data_o = ~wd;  // released bus must not keep the old byte
    for (n = 0; n < 10 && ack_oe_i !== 1'b0; n++) @(posedge clk_i);
    if (ack_oe_i !== 1'b0) ok = 1'b0;
  endtask : access
endmodule : tsima_host_model
`default_nettype wire

// File: tb/tsima_top_test.sv
/*
  Self-checking bench for the switch addressing block: control register,
  paged memory window and slot lookups.
  Assumes the host model drives the parallel port pins.
*/
`timescale 1ns/1ns
`default_nettype none
module tsima_top_test
  import tsima_pkg::*;
;
  logic clk_i, reset_i, cs_n, ds, rw, ack_oe, slot_req, rx_wr, slot_valid_o, slot_direct_o, pe_o;
  logic [5:0] addr;
  logic [7:0] wdata, data_o, rx_d, slot_data_o, rdat;
  logic [2:0] slot_st, rx_st, slot_src_stream_o;
  logic [4:0] slot_ch, rx_ch, slot_src_chan_o;
  logic       data_oe, ack_n;
  logic [1:0] drv_q;
  int n_errors = 0;
  int compares = 0;

  tsima_top DUT (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .ds_i(ds), .rw_i(rw),
    .addr_i(addr), .data_i(wdata), .data_o(data_o), .data_oe_o(data_oe), .transfer_ack_n_o(ack_n),
    .transfer_ack_oe_o(ack_oe), .slot_req_i(slot_req), .slot_stream_i(slot_st),
    .slot_chan_i(slot_ch), .rx_wr_i(rx_wr), .rx_stream_i(rx_st), .rx_chan_i(rx_ch),
    .rx_data_i(rx_d), .slot_valid_o(slot_valid_o), .slot_direct_o(slot_direct_o),
    .slot_src_stream_o(slot_src_stream_o), .slot_src_chan_o(slot_src_chan_o),
    .slot_data_o(slot_data_o), .processor_output_mode_o(pe_o));

  tsima_host_model HOST (.clk_i(clk_i), .ack_oe_i(ack_oe), .rdata_i(data_o), .cs_n_o(cs_n),
    .ds_o(ds), .rw_o(rw), .addr_o(addr), .data_o(wdata));

  // pin levels at each acknowledged edge: ack pin value, data bus drive
  always @(posedge clk_i) begin
    if (ack_oe === 1'b1) drv_q <= {ack_n, data_oe};
  end

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // a hung handshake ends the run rather than cascading
  task automatic bus(input logic r, input logic [5:0] a, input logic [7:0] d, input int hold);
    logic ok;
    HOST.access(r, a, d, hold, rdat, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR acknowledge expected 1 seen 0");
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 0);
    check("write pin drive", 8'h00, {6'h00, drv_q});
  endtask : wr

  task automatic rd(input string w, input logic [5:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h00, 2);
    check(w, e, rdat);
    check("read pin drive", 8'h01, {6'h00, drv_q});
  endtask : rd

  task automatic rxw(input logic [2:0] s, input logic [4:0] c, input logic [7:0] d);
    @(negedge clk_i);
    rx_wr = 1'b1;
    rx_st = s;
    rx_ch = c;
    rx_d  = d;
    @(negedge clk_i);
    rx_wr = 1'b0;
  endtask : rxw

  // lookup one slot; b is its source-select byte, d the data expected out
  task automatic slot(input logic [2:0] s, input logic [4:0] c, input logic dir,
                      input logic [7:0] d, input logic [7:0] b);
    int n;
    @(negedge clk_i);
    slot_req = 1'b1;
    slot_st  = s;
    slot_ch  = c;
    for (n = 1; n <= 5; n++) begin
      @(negedge clk_i);
      slot_req = 1'b0;
      if (slot_valid_o === 1'b1) break;
    end
    check("slot latency", 8'h03, 8'(n));
    if (n > 5) end_sim();
    check("slot direct", {7'h00, dir}, {7'h00, slot_direct_o});
    check("slot data", d, slot_data_o);
    check("slot src stream", {5'h00, b[7:5]}, {5'h00, slot_src_stream_o});
    check("slot src chan", {3'h0, b[4:0]}, {3'h0, slot_src_chan_o});
  endtask : slot

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset_i  = 1'b1;
    slot_req = 1'b0;
    slot_st  = 3'h0;
    slot_ch  = 5'h00;
    rx_wr    = 1'b0;
    rx_st    = 3'h0;
    rx_ch    = 5'h00;
    rx_d     = 8'h00;
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    rd("control reset", 6'h00, CR_RESET);
    check("pe reset", 8'h00, {7'h00, pe_o});
    wr(6'h1d, 8'h35);
    rd("control alias a", 6'h02, 8'h35);
    rd("control alias b", 6'h1f, 8'h35);
    $display("test control register done");
    // every stream page of the source-select memory holds its own bytes
    for (int s = 0; s < 8; s++) begin
      wr(6'h00, {3'h0, 2'h2, 3'(s)});
      for (int c = 0; c < 32; c++) wr({1'b1, 5'(c)}, {3'(s), 5'(c)} ^ 8'ha5);
    end
    for (int s = 0; s < 8; s++) begin
      wr(6'h00, {3'h0, 2'h2, 3'(s)});
      for (int c = 0; c < 32; c++) rd("page byte", {1'b1, 5'(c)}, {3'(s), 5'(c)} ^ 8'ha5);
    end
    $display("test paged window done");
    wr(6'h00, 8'h0a);
    wr(6'h25, 8'h04);
    wr(6'h29, 8'h00);
    rd("output control", 6'h25, 8'h04);
    rxw(3'h2, 5'h09, 8'h3c);
    rxw(3'h3, 5'h17, 8'hc3);
    wr(6'h00, 8'h1a);
    rd("data memory", 6'h29, 8'h3c);
    wr(6'h29, 8'hff);
    rd("data read only", 6'h29, 8'h3c);
    wr(6'h00, 8'h8a);
    wr(6'h29, 8'h77);
    rd("split read", 6'h29, 8'h3c);
    wr(6'h00, 8'h02);
    wr(6'h29, 8'h11);
    rd("no select", 6'h29, 8'h00);
    wr(6'h00, 8'h12);
    rd("split write", 6'h29, 8'h77);
    $display("test memory select done");
    slot(3'h2, 5'h09, 1'b0, 8'hc3, 8'h77);
    slot(3'h2, 5'h05, 1'b1, 8'he0, 8'he0);
    wr(6'h00, 8'h52);
    check("pe level", 8'h01, {7'h00, pe_o});
    slot(3'h2, 5'h09, 1'b1, 8'h77, 8'h77);
    $display("test slot lookup done");
    end_sim();
  end
endmodule : tsima_top_test
`default_nettype wire
